/* File: common/pmrc_regs.svh */
// Register map, field positions, reset values and timing constants of the
// power-mode and reset-control block. Definitions only; include by bare name.
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH

// Byte addresses on the register port
`define PMRC_RSR_ADDR        32'h0100_0008
`define PMRC_OPC_ADDR        32'h0100_0010
`define PMRC_LPC_ADDR        32'h0100_0014

// Oscillator and power control fields and reset value
`define PMRC_OPC_RESET       32'h0000_1500
`define PMRC_OPC_WMASK       32'h0000_FF74
`define PMRC_OPC_ST_HI       15
`define PMRC_OPC_ST_LO       8
`define PMRC_OPC_SUSPN_BIT   6
`define PMRC_OPC_BYP_BIT     5
`define PMRC_OPC_XON_BIT     4
`define PMRC_OPC_SCS_BIT     2

// Low-power control fields and reset value
`define PMRC_LPC_RESET       32'h0000_0000
`define PMRC_LPC_DUTY_HI     7
`define PMRC_LPC_DUTY_LO     3
`define PMRC_LPC_DOZE_BIT    2
`define PMRC_LPC_LPM_HI      1
`define PMRC_LPC_LPM_LO      0
`define PMRC_LPM_IDLE        2'h0
`define PMRC_LPM_SLEEP       2'h1

// Reset cause status fields
`define PMRC_RSR_WR_BIT      1
`define PMRC_RSR_PR_BIT      0

// Timing
`define PMRC_CLK_PERIOD_NS   25
`define PMRC_POR_STRETCH_MS  40
`define PMRC_WDT_STRETCH_MS  10
`define PMRC_NS_PER_MS       1000000
`define PMRC_DUTY_SLOTS      5'h1F
`define PMRC_SLOW_DIV_W      9
`define PMRC_STAB_UNIT_LOG2  4

`endif

/* File: common/pmrc_pkg.sv */
// Types shared by the power-mode and reset-control block.
// Assumes the constants of pmrc_regs.svh for field widths.
package pmrc_pkg;

	// Register port request
	typedef struct packed {
		logic [31:0] addr;   // Byte address
		logic [31:0] wdata;  // Write data
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
	} pmrc_bus_req_t;

	// Clock and power controls sent to the rest of the chip
	typedef struct packed {
		logic core_clock_en;     // Core clock gate
		logic periph_clock_en;   // Peripheral clock gate
		logic pll_en;            // PLL running
		logic crystal_direct;    // Clocks taken straight from the crystal
		logic crystal_en;        // Crystal oscillator running
		logic clock_output_en;   // External clock output pin running
		logic arbiter_hold;      // Arbiter grants no further request
		logic self_refresh_req;  // Memory controller to self-refresh
	} pmrc_clk_ctrl_t;

	// Power mode sequencer, one-hot
	typedef enum logic [5:0] {
		PMRC_ST_RUN   = 6'h01,
		PMRC_ST_IWAIT = 6'h02,
		PMRC_ST_IDLE  = 6'h04,
		PMRC_ST_DRAIN = 6'h08,
		PMRC_ST_SLEEP = 6'h10,
		PMRC_ST_WAKE  = 6'h20
	} pmrc_state_t;

endpackage

/* File: design/pmrc_top.sv */
// Power-mode and reset-control block: oscillator/power control, low-power
// control, doze slotting, idle and sleep sequencing, reset stretching and
// reset cause recording. Assumes ref_clk is the crystal clock and that the
// core, arbiter and memory controller run on it; reset pin and 32 kHz clock
// arrive asynchronously.
//
// Summary of operation
// [RULE_01] 32-bit oscillator control register, resets 0x00001500
// [RULE_02] Bits 15:8 stabilize time, 16 slow periods
// [RULE_03] Bit 6 low forces transceiver suspend
// [RULE_04] Bit 4 keeps crystal running in sleep
// [RULE_05] Bit 2 picks 32 kHz or crystal/512
// [RULE_06] Reserved bits read zero, writes ignored
// [RULE_07] Doze halts core when its slot expires
// [RULE_08] Doze duty adjustable in 1/31 steps
// [RULE_09] Doze ends on write, interrupt, reset, SLEEP
// [RULE_10] Idle: wait core idle, stop core clock
// [RULE_11] Idle ends only on interrupt or reset
// [RULE_12] Sleep: hold arbiter, request SDRAM self-refresh
// [RULE_13] Stop clocks after bus idle and self-refresh
// [RULE_14] Sleep stops PLL and clock output pin
// [RULE_15] Sleep ends on interrupt, watchdog or pin reset
// [RULE_16] Watchdog cause bit set, cleared only by 0; a pin reset also clears it
// [RULE_17] Pin reset cause bit set, cleared by 0
// [RULE_18] Pin low: reset at once, stretch 40 ms
// [RULE_19] During reset PLL off, crystal clocks direct
// [RULE_20] Watchdog overflow asserts reset within two slow cycles
// [RULE_21] Watchdog reset held 10 ms, clears source
// [RULE_22] Low-power select: 00 idle, 01 sleep
// [RULE_23] Doze bit self-clears when doze cancelled
// [RULE_24] Duty field gives value over 31
`include "pmrc_regs.svh"

module pmrc_top #(
	parameter int POR_CYCLES = (`PMRC_POR_STRETCH_MS * `PMRC_NS_PER_MS) / `PMRC_CLK_PERIOD_NS,
	parameter int WDT_CYCLES = (`PMRC_WDT_STRETCH_MS * `PMRC_NS_PER_MS) / `PMRC_CLK_PERIOD_NS
) (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire pmrc_pkg::pmrc_bus_req_t  bus_req,
	output logic [31:0]                   reg_rdata,
	input  wire logic                     external_reset_pin_n,
	input  wire logic                     slow_32k_clock,
	input  wire logic                     watchdog_overflow,
	input  wire logic                     sleep_exec,
	input  wire logic                     core_idle,
	input  wire logic                     irq,
	input  wire logic                     bus_idle,
	input  wire logic                     sdram_self_refresh,
	output logic                          internal_reset,
	output logic                          watchdog_source_clear,
	output pmrc_pkg::pmrc_clk_ctrl_t      clk_ctrl,
	output logic                          slow_clock_out,
	output logic                          transceiver_forced_suspend,
	output logic                          bypass_select,
	output logic                          doze_active
);

	localparam int PW = $clog2(POR_CYCLES + 1);  // Stretch counter widths
	localparam int WW = $clog2(WDT_CYCLES + 1);
	localparam logic [PW-1:0] POR_LOAD = PW'(POR_CYCLES);
	localparam logic [WW-1:0] WDT_LOAD = WW'(WDT_CYCLES);

	// Synchronisers and stretch counters
	logic          rpin_m_q, rpin_s_q;            // Reset pin, two stages
	logic          s32_m_q, s32_s_q, s32_p_q;     // 32 kHz clock, two stages plus history
	logic [PW-1:0] por_cnt_q, por_cnt_d;          // Power-on stretch remaining
	logic [WW-1:0] wdt_cnt_q, wdt_cnt_d;          // Watchdog stretch remaining
	// Registers
	logic [31:0]   opc_q, opc_d;                  // Oscillator and power control
	logic [31:0]   lpc_q, lpc_d;                  // Low-power control
	logic [1:0]    rsr_q, rsr_d;                  // Reset cause bits
	logic [31:0]   rdata_q, rdata_d;              // Read data, one cycle late
	// Sequencing
	pmrc_pkg::pmrc_state_t st_q, st_d;            // Power mode state
	logic [4:0]    slot_q, slot_d;                // Doze slot position
	logic [`PMRC_SLOW_DIV_W-1:0] div_q;           // Crystal/512 divider
	logic [11:0]   stab_q, stab_d;                // Stabilize tick counter
	logic          slow_q;                        // Registered slow clock out

	// Reset sources
	wire pin_low   = ~rpin_s_q;
	wire por_busy  = (por_cnt_q != '0);
	wire wdt_busy  = (wdt_cnt_q != '0);
	wire wdt_event = watchdog_overflow & ~wdt_busy;
	wire int_rst   = pin_low | por_busy | wdt_busy;

	// Address decode
	wire sel_opc = (bus_req.addr == `PMRC_OPC_ADDR);
	wire sel_lpc = (bus_req.addr == `PMRC_LPC_ADDR);
	wire sel_rsr = (bus_req.addr == `PMRC_RSR_ADDR);
	wire wr_opc  = bus_req.wr & sel_opc;
	wire wr_lpc  = bus_req.wr & sel_lpc;
	wire wr_rsr  = bus_req.wr & sel_rsr;

	// Fields
	wire [7:0] stab_time = opc_q[`PMRC_OPC_ST_HI:`PMRC_OPC_ST_LO];
	wire       xon_sleep = opc_q[`PMRC_OPC_XON_BIT];
	wire       scs_32k   = opc_q[`PMRC_OPC_SCS_BIT];
	wire [4:0] duty      = lpc_q[`PMRC_LPC_DUTY_HI:`PMRC_LPC_DUTY_LO];
	wire       doze      = lpc_q[`PMRC_LPC_DOZE_BIT];
	wire [1:0] low_power_select       = lpc_q[`PMRC_LPC_LPM_HI:`PMRC_LPC_LPM_LO];

	// Slow tick: 32 kHz edge or crystal/512 wrap
	wire       edge_32k  = s32_s_q & ~s32_p_q;
	wire       div_wrap  = (div_q == '1);
	wire       slow_tick = scs_32k ? edge_32k : div_wrap;  // [RULE_05]
	wire [11:0] stab_end = {stab_time, {`PMRC_STAB_UNIT_LOG2{1'b0}}};  // [RULE_02]

	// Doze: core runs only inside its share of the 31 slots
	wire in_slot  = (slot_q < duty);  // [RULE_08] [RULE_24]
	wire doze_end = irq | sleep_exec | int_rst;  // [RULE_09]

	// Synchronisers; logic reads the second stage and the 32 kHz history, never the first stage
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rpin_m_q <= 1'b1;
			rpin_s_q <= 1'b1;
			s32_m_q  <= 1'b0;
			s32_s_q  <= 1'b0;
			s32_p_q  <= 1'b0;
		end else begin
			rpin_m_q <= external_reset_pin_n;
			rpin_s_q <= rpin_m_q;
			s32_m_q  <= slow_32k_clock;
			s32_s_q  <= s32_m_q;
			s32_p_q  <= s32_s_q;
		end
	end

	// Stretch counters: the pin reloads for as long as it is low
	always_comb begin
		por_cnt_d = por_cnt_q;
		if (pin_low)
			por_cnt_d = POR_LOAD;  // [RULE_18]
		else if (por_busy)
			por_cnt_d = por_cnt_q - PW'(1);
		wdt_cnt_d = wdt_cnt_q;
		if (pin_low)
			wdt_cnt_d = '0;  // Pin reset takes over from a watchdog reset
		else if (wdt_event)
			wdt_cnt_d = WDT_LOAD;  // [RULE_20] [RULE_21]
		else if (wdt_busy)
			wdt_cnt_d = wdt_cnt_q - WW'(1);
	end

	// Counter flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			por_cnt_q <= '0;
			wdt_cnt_q <= '0;
		end else begin
			por_cnt_q <= por_cnt_d;
			wdt_cnt_q <= wdt_cnt_d;
		end
	end

	// Register next values; internal reset restores control registers
	always_comb begin
		opc_d = opc_q;
		lpc_d = lpc_q;
		if (int_rst) begin
			opc_d = `PMRC_OPC_RESET;  // [RULE_01]
			lpc_d = `PMRC_LPC_RESET;
		end else begin
			if (wr_opc)
				opc_d = bus_req.wdata & `PMRC_OPC_WMASK;  // [RULE_06]
			if (wr_lpc)
				lpc_d = {24'h00_0000, bus_req.wdata[7:0]};
			// Hardware cancel wins over a software set in the same cycle
			if (doze_end)
				lpc_d[`PMRC_LPC_DOZE_BIT] = 1'b0;  // [RULE_23]
		end
	end

	// Cause bits: a new reset clears the other cause; set beats clear
	always_comb begin
		rsr_d = rsr_q;
		if (wr_rsr)
			rsr_d = rsr_q & bus_req.wdata[1:0];  // [RULE_16] [RULE_17]
		if (pin_low) begin
			rsr_d[`PMRC_RSR_PR_BIT] = 1'b1;  // [RULE_17]
			rsr_d[`PMRC_RSR_WR_BIT] = 1'b0;
		end else if (wdt_event) begin
			rsr_d[`PMRC_RSR_WR_BIT] = 1'b1;  // [RULE_16]
			rsr_d[`PMRC_RSR_PR_BIT] = 1'b0;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (bus_req.rd) begin
			if (sel_opc)
				rdata_d = opc_q;  // [RULE_06]
			else if (sel_lpc)
				rdata_d = lpc_q;
			else if (sel_rsr)
				rdata_d = {30'h0000_0000, rsr_q};
		end
	end

	// Register flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			opc_q   <= `PMRC_OPC_RESET;  // [RULE_01]
			lpc_q   <= `PMRC_LPC_RESET;
			rsr_q   <= 2'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			opc_q   <= opc_d;
			lpc_q   <= lpc_d;
			rsr_q   <= rsr_d;
			rdata_q <= rdata_d;
		end
	end

	// Power mode sequencer
	always_comb begin
		st_d   = st_q;
		stab_d = stab_q;
		unique case (st_q)
			pmrc_pkg::PMRC_ST_RUN: begin
				// Reserved select codes leave the core running
				if (sleep_exec && low_power_select == `PMRC_LPM_IDLE)
					st_d = pmrc_pkg::PMRC_ST_IWAIT;  // [RULE_22]
				else if (sleep_exec && low_power_select == `PMRC_LPM_SLEEP)
					st_d = pmrc_pkg::PMRC_ST_DRAIN;  // [RULE_22]
			end
			pmrc_pkg::PMRC_ST_IWAIT: begin
				// Core clock still runs so the current operation can finish
				if (core_idle)
					st_d = pmrc_pkg::PMRC_ST_IDLE;  // [RULE_10]
			end
			pmrc_pkg::PMRC_ST_IDLE: begin
				// Only an interrupt wakes here; resets are taken below
				if (irq)
					st_d = pmrc_pkg::PMRC_ST_RUN;  // [RULE_11]
			end
			pmrc_pkg::PMRC_ST_DRAIN: begin
				// Core clock is off; PLL and peripheral clocks keep running until bus and memory both confirm
				if (bus_idle && sdram_self_refresh)
					st_d = pmrc_pkg::PMRC_ST_SLEEP;  // [RULE_13]
			end
			pmrc_pkg::PMRC_ST_SLEEP: begin
				stab_d = 12'h000;
				if (irq)
					st_d = xon_sleep ? pmrc_pkg::PMRC_ST_RUN : pmrc_pkg::PMRC_ST_WAKE;  // [RULE_15]
			end
			pmrc_pkg::PMRC_ST_WAKE: begin
				// Crystal restarted; wait out its stabilize time
				if (stab_q >= stab_end)
					st_d = pmrc_pkg::PMRC_ST_RUN;  // [RULE_02]
				else if (slow_tick)
					stab_d = stab_q + 12'h001;
			end
		endcase
		// A reset from any source overrides every mode
		if (int_rst) begin
			st_d   = pmrc_pkg::PMRC_ST_RUN;  // [RULE_15]
			stab_d = 12'h000;
		end
	end

	// Doze slot counter runs 0..30 and wraps
	always_comb begin
		slot_d = slot_q + 5'h01;
		if (slot_q == `PMRC_DUTY_SLOTS - 5'h01)
			slot_d = 5'h00;
	end

	// Sequencer and slot flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q   <= pmrc_pkg::PMRC_ST_RUN;
			stab_q <= 12'h000;
			slot_q <= 5'h00;
		end else begin
			st_q   <= st_d;
			stab_q <= stab_d;
			slot_q <= slot_d;
		end
	end

	// Divider and slow clock output, both free running on the crystal
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			div_q  <= '0;
			slow_q <= 1'b0;
		end else begin
			div_q  <= div_q + `PMRC_SLOW_DIV_W'(1);
			slow_q <= scs_32k ? s32_s_q : div_q[`PMRC_SLOW_DIV_W-1];  // [RULE_05]
		end
	end

	// Clock controls
	wire run_st   = (st_q == pmrc_pkg::PMRC_ST_RUN);
	wire iwait_st = (st_q == pmrc_pkg::PMRC_ST_IWAIT);
	wire idle_st  = (st_q == pmrc_pkg::PMRC_ST_IDLE);
	wire drain_st = (st_q == pmrc_pkg::PMRC_ST_DRAIN);
	wire sleep_st = (st_q == pmrc_pkg::PMRC_ST_SLEEP);
	wire wake_st  = (st_q == pmrc_pkg::PMRC_ST_WAKE);
	// Arbiter stays held until the core runs again, so no access meets a stopped clock
	wire hold_st  = drain_st | sleep_st | wake_st;
	wire off_st   = sleep_st | wake_st;
	// Core keeps its registers while gated; only the clock stops
	assign clk_ctrl.core_clock_en    = (run_st & (~doze | in_slot)) | iwait_st;  // [RULE_07] [RULE_10]
	assign clk_ctrl.periph_clock_en  = ~off_st;  // [RULE_13]
	assign clk_ctrl.pll_en           = ~int_rst & ~off_st;  // [RULE_14] [RULE_19]
	assign clk_ctrl.crystal_direct   = int_rst;  // [RULE_19]
	assign clk_ctrl.crystal_en       = ~(sleep_st & ~xon_sleep);  // [RULE_04]
	assign clk_ctrl.clock_output_en  = ~off_st;  // [RULE_14]
	assign clk_ctrl.arbiter_hold     = hold_st;  // [RULE_12]
	assign clk_ctrl.self_refresh_req = hold_st;  // [RULE_12]

	assign internal_reset             = int_rst;  // [RULE_18] [RULE_20]
	assign watchdog_source_clear      = wdt_busy;  // [RULE_21]
	assign reg_rdata                  = rdata_q;
	assign slow_clock_out             = slow_q;
	assign transceiver_forced_suspend = ~opc_q[`PMRC_OPC_SUSPN_BIT];  // [RULE_03]
	assign bypass_select              = opc_q[`PMRC_OPC_BYP_BIT];
	assign doze_active                = doze & run_st;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence drain_done_s;
		bus_idle && sdram_self_refresh;
	endsequence

	sequence in_drain_s;
		drain_st;
	endsequence

	// Crystal not yet stable after a wake from sleep
	sequence wake_wait_s;
		wake_st && stab_q < stab_end;
	endsequence

	// Software writes ones to both cause bits with no reset event pending
	sequence keep_write_s;
		wr_rsr && bus_req.wdata[1:0] == 2'h3 && !pin_low && !wdt_event;
	endsequence

	opc_reset_a: assert property (int_rst |=> opc_q == `PMRC_OPC_RESET)  // [RULE_01]
		else $error("control register not restored by reset");
	reserved_zero_a: assert property (bus_req.rd && sel_opc |=> reg_rdata[31:16] == 16'h0000)  // [RULE_06]
		else $error("reserved bits read nonzero");
	wdt_flag_a: assert property (wdt_event && !pin_low |=> rsr_q == 2'h2)  // [RULE_16]
		else $error("watchdog cause not recorded");
	pin_flag_a: assert property (pin_low |=> rsr_q[0] && !rsr_q[1] && int_rst)  // [RULE_17]
		else $error("pin reset cause not recorded");
	sleep_entry_a: assert property (in_drain_s ##1 sleep_st |-> $past(bus_idle && sdram_self_refresh))  // [RULE_13]
		else $error("clocks stopped before bus and memory ready");
	drain_exit_a: assert property (in_drain_s ##0 drain_done_s ##0 !int_rst |=> sleep_st)  // [RULE_12]
		else $error("sleep not entered after drain");
	idle_gate_a: assert property (idle_st |-> !clk_ctrl.core_clock_en)  // [RULE_10]
		else $error("core clock runs in idle");
	sleep_pll_a: assert property (sleep_st |-> !clk_ctrl.pll_en && !clk_ctrl.clock_output_en)  // [RULE_14]
		else $error("PLL or clock pin active in sleep");
	idle_hold_a: assert property (idle_st && !irq && !int_rst |=> idle_st)  // [RULE_11]
		else $error("idle left without interrupt");
	wake_wait_a: assert property (wake_wait_s ##0 !int_rst |=> !run_st)  // [RULE_02]
		else $error("core resumed before crystal stable");
	cause_keep_a: assert property (keep_write_s |=> rsr_q == $past(rsr_q))  // [RULE_16] [RULE_17]
		else $error("cause bit changed by a write of one");
	reserved_lpm_a: assert property (run_st && sleep_exec && low_power_select[1] && !int_rst |=> run_st)  // [RULE_22]
		else $error("reserved select code left run");
	doze_slot_a: assert property (doze && run_st && !in_slot |-> !clk_ctrl.core_clock_en)  // [RULE_07]
		else $error("core clocked outside its doze slot");
	wdt_reset_a: assert property (wdt_event && !pin_low |=> internal_reset [*8])  // [RULE_20] [RULE_21]
		else $error("watchdog reset not asserted");
	doze_cancel_a: assert property (doze && irq |=> !doze)  // [RULE_23]
		else $error("doze not cancelled by interrupt");
	reset_clock_a: assert property (int_rst |-> clk_ctrl.crystal_direct && !clk_ctrl.pll_en)  // [RULE_19]
		else $error("PLL on during reset");

endmodule // pmrc_top

/* File: bench/pmrc_partner.sv */
// Behavioural core, bus arbiter and memory controller on the far side.
// Assumes the control struct of pmrc_top and the bench's sleep and irq.
module pmrc_partner #(
	parameter int DLY = 4  // Cycles of work still in flight
) (
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	input  wire pmrc_pkg::pmrc_clk_ctrl_t  clk_ctrl,
	input  wire logic                      sleep_exec,
	input  wire logic                      irq,
	output logic                           core_idle,
	output logic                           bus_idle,
	output logic                           sdram_self_refresh
);
	timeunit 1ns;
	timeprecision 1ps;
	int   idle_cnt;  // Core work left after SLEEP
	logic armed;     // Core is winding down
	int   bus_cnt;   // Cycles of hold so far, up to DLY

	// Known levels before the first edge
	initial begin
		core_idle = 1'b0;
		bus_idle = 1'b0;
		sdram_self_refresh = 1'b0;
	end

	// Core idles late; bus idles late; memory confirms one cycle after the bus
	always @(posedge ref_clk) begin
		if (srst) begin
			armed <= 1'b0;
			idle_cnt <= 0;
			bus_cnt <= 0;
		end else if (sleep_exec) begin
			armed <= 1'b1;
			idle_cnt <= DLY;
		end else if (irq) begin
			armed <= 1'b0;
		end else if (idle_cnt != 0) begin
			idle_cnt <= idle_cnt - 1;
		end
		core_idle <= armed && idle_cnt == 0 && !sleep_exec && !srst;
		// Bus stays busy while not held, so no early idle is shown
		bus_cnt <= clk_ctrl.arbiter_hold ? ((bus_cnt == DLY) ? bus_cnt : bus_cnt + 1) : 0;
		bus_idle <= clk_ctrl.arbiter_hold && bus_cnt == DLY;
		sdram_self_refresh <= clk_ctrl.self_refresh_req && bus_idle;
	end
endmodule // pmrc_partner

/* File: bench/pmrc_top_tb.sv */
// Self-checking bench for pmrc_top: register port tasks and mode sequences.
// Assumes the partner model answers on the core and bus side.
`include "pmrc_regs.svh"
module pmrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR_C = 20;  // Short stretches keep the run brief
	localparam int WDT_C = 10;
	logic                     ref_clk = 1'b0;
	logic                     srst = 1'b1;
	pmrc_pkg::pmrc_bus_req_t  bus_req = '0;
	logic [31:0]              reg_rdata;
	logic                     pin_n = 1'b1;
	logic                     slow_clk = 1'b0;
	logic                     wdt = 1'b0;
	logic                     sleep_exec = 1'b0;
	logic                     irq = 1'b0;
	logic                     core_idle;
	logic                     bus_idle;
	logic                     sdram_sr;
	logic                     internal_reset;
	logic                     src_clr;
	pmrc_pkg::pmrc_clk_ctrl_t c;
	logic                     slow_out;
	logic                     susp;
	logic                     byp;
	logic                     doze;
	int                       fail_count = 0;
	int                       check_count = 0;
	int                       n;
	int                       i;
	int                       k;
	logic [31:0]              v;
	int                       duty [5] = '{0, 1, 10, 30, 31};

	pmrc_top #(.POR_CYCLES(POR_C), .WDT_CYCLES(WDT_C)) dut (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .external_reset_pin_n(pin_n), .slow_32k_clock(slow_clk),
		.watchdog_overflow(wdt), .sleep_exec(sleep_exec), .core_idle(core_idle), .irq(irq),
		.bus_idle(bus_idle), .sdram_self_refresh(sdram_sr), .internal_reset(internal_reset),
		.watchdog_source_clear(src_clr), .clk_ctrl(c), .slow_clock_out(slow_out),
		.transceiver_forced_suspend(susp), .bypass_select(byp), .doze_active(doze));
	pmrc_partner partner (.ref_clk(ref_clk), .srst(srst), .clk_ctrl(c), .sleep_exec(sleep_exec), .irq(irq),
		.core_idle(core_idle), .bus_idle(bus_idle), .sdram_self_refresh(sdram_sr));

	// Crystal clock, 40 MHz, and an unrelated 32 kHz clock
	initial forever #12.5 ref_clk = ~ref_clk;
	initial forever #15259 slow_clk = ~slow_clk;

	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic tick(input int t);
		repeat (t) @(negedge ref_clk);
	endtask
	// One-cycle write; the slave never stalls
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic pulse(input int which);
		@(posedge ref_clk);
		if (which == 0) sleep_exec <= 1'b1;
		else irq <= 1'b1;
		@(posedge ref_clk);
		sleep_exec <= 1'b0;
		irq <= 1'b0;
	endtask
	// Cycles up to the next rise of the slow clock output
	task automatic gap(output int g);
		logic p;
		g = 0;
		p = slow_out;
		while (g < 3000 && !(p === 1'b0 && slow_out === 1'b1)) begin
			p = slow_out;
			@(negedge ref_clk);
			g++;
		end
	endtask

	// Watchdog on the whole run
	initial begin
		#1500000;
		fail_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`PMRC_RSR_ADDR, v); check("rsr reset", v, 32'h0);
		rd(`PMRC_OPC_ADDR, v); check("opc reset", v, `PMRC_OPC_RESET);
		tick(1); check("rdata after", reg_rdata, 32'h0);
		rd(32'h0100_0020, v); check("unmapped", v, 32'h0);
		wr(`PMRC_OPC_ADDR, 32'hFFFF_FFFF);
		rd(`PMRC_OPC_ADDR, v); check("opc mask", v, 32'h0000_FF74);
		check("suspend off", susp, 1'b0);
		check("bypass", byp, 1'b1);
		wr(`PMRC_OPC_ADDR, 32'h0);
		tick(1); check("suspend on", susp, 1'b1);
		// Divided crystal, then the 32 kHz clock
		gap(n); gap(n); check("div gap", n, 512);
		wr(`PMRC_OPC_ADDR, 32'h0000_0004);
		gap(n); gap(n); check("32k gap", n >= 1219 && n <= 1222, 1'b1);
		// Doze duty table
		for (i = 0; i < 5; i++) begin
			wr(`PMRC_LPC_ADDR, (duty[i] << 3) | 4);
			tick(2);
			n = 0;
			repeat (31) begin
				@(negedge ref_clk);
				n += (c.core_clock_en === 1'b1) ? 1 : ((c.core_clock_en === 1'b0) ? 0 : 99);
			end
			check("doze duty", n, duty[i]);
		end
		check("doze on", doze, 1'b1);
		wr(`PMRC_LPC_ADDR, 32'h50);
		tick(1); check("doze by write", doze, 1'b0);
		wr(`PMRC_LPC_ADDR, 32'h54);
		pulse(1);
		rd(`PMRC_LPC_ADDR, v); check("doze by irq", v, 32'h50);
		// Idle entry waits for the core
		wr(`PMRC_LPC_ADDR, 32'hFC);
		pulse(0);
		tick(1); check("idle wait", c.core_clock_en, 1'b1);
		for (i = 0; i < 20 && c.core_clock_en !== 1'b0; i++) tick(1);
		check("idle after core", core_idle, 1'b1);
		rd(`PMRC_LPC_ADDR, v); check("doze by sleep", v, 32'hF8);
		wr(`PMRC_LPC_ADDR, 32'hF8);
		tick(4); check("idle holds", c.core_clock_en, 1'b0);
		pulse(1);
		tick(1); check("idle exit", c.core_clock_en, 1'b1);
		// Reserved select codes do nothing
		for (i = 2; i < 4; i++) begin
			wr(`PMRC_LPC_ADDR, i);
			pulse(0);
			tick(3); check("reserved", {c.arbiter_hold, c.core_clock_en}, 2'b01);
		end
		// Sleep with crystal kept, then with crystal off
		for (k = 1; k >= 0; k--) begin
			wr(`PMRC_OPC_ADDR, k ? 32'h0110 : 32'h0100);
			wr(`PMRC_LPC_ADDR, 32'h1);
			pulse(0);
			tick(1); check("drain", {c.arbiter_hold, c.self_refresh_req, c.pll_en}, 3'b111);
			for (i = 0; i < 20 && c.pll_en !== 1'b0; i++) tick(1);
			check("stop after idle", {bus_idle, sdram_sr}, 2'b11);
			check("sleep clocks", {c.clock_output_en, c.periph_clock_en}, 2'b00);
			check("crystal in sleep", c.crystal_en, k);
			tick(5); check("sleep holds", c.pll_en, 1'b0);
			pulse(1);
			tick(1);
			for (n = 0; n < 9000 && c.pll_en !== 1'b1; n++) tick(1);
			if (k) check("wake fast", n <= 2, 1'b1);
			else check("wake stabilize", n >= 7680 && n <= 8300, 1'b1);
		end
		// Watchdog reset
		wr(`PMRC_OPC_ADDR, 32'hFFFF);
		@(posedge ref_clk);
		wdt <= 1'b1;
		@(posedge ref_clk);
		wdt <= 1'b0;
		n = 0;
		for (i = 0; i < WDT_C + 5; i++) begin
			@(negedge ref_clk);
			if (i == 0) check("wdt prompt", internal_reset, 1'b1);
			if (internal_reset === 1'b1) n++;
			check("wdt clear", src_clr, internal_reset);
			if (i == 1) check("wdt clocks", {c.pll_en, c.crystal_direct}, 2'b01);
		end
		check("wdt length", n, WDT_C);
		rd(`PMRC_OPC_ADDR, v); check("opc restored", v, `PMRC_OPC_RESET);
		wr(`PMRC_RSR_ADDR, 32'h2);
		rd(`PMRC_RSR_ADDR, v); check("rsr wdt", v, 32'h2);
		// Pin reset
		@(posedge ref_clk);
		pin_n <= 1'b0;
		tick(3); check("pin prompt", internal_reset, 1'b1);
		check("pin clocks", {c.pll_en, c.crystal_direct}, 2'b01);
		tick(5);
		@(posedge ref_clk);
		pin_n <= 1'b1;
		n = 0;
		for (i = 0; i < POR_C + 20; i++) begin
			@(negedge ref_clk);
			if (internal_reset === 1'b1) n++;
		end
		check("por length", n >= POR_C && n <= POR_C + 4, 1'b1);
		rd(`PMRC_RSR_ADDR, v); check("rsr pin", v, 32'h1);
		wr(`PMRC_RSR_ADDR, 32'h3);
		rd(`PMRC_RSR_ADDR, v); check("rsr one", v, 32'h1);
		wr(`PMRC_RSR_ADDR, 32'h0);
		rd(`PMRC_RSR_ADDR, v); check("rsr zero", v, 32'h0);
		end_sim();
	end
endmodule // pmrc_top_tb
